// ===== verilog/emb_pkg.sv
// Constants, types and timing for the external memory bus port
package emb_pkg;

  localparam int          CLK_PERIOD_NS = 4;
  // Strobe widths in ns; least times round up to whole cycles
  localparam int          AS_LOW_NS     = 8;
  localparam int          DS_LOW_NS     = 24;
  localparam int          AS_LOW_CYC    = (AS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DS_LOW_CYC    = (DS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  AS_LAST       = 3'(AS_LOW_CYC - 1);
  localparam logic [2:0]  DS_LAST       = 3'(DS_LOW_CYC - 1);
  localparam logic [2:0]  CNT_ZERO      = 3'h0;

  // On-chip program memory occupies the low 8K bytes of program space
  localparam int          ONCHIP_AW     = 13;
  localparam logic [15:0] ONCHIP_LIMIT  = 16'h2000;
  localparam logic [15:0] VEC_HI_ADDR   = 16'h0000;
  localparam logic [15:0] VEC_LO_ADDR   = 16'h0001;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;

  // One bus request from the core side
  typedef struct packed {
    logic        write;
    logic        prog;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } emb_req_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_AS    = 6'b00_0010,
    ST_AHOLD = 6'b00_0100,
    ST_DS    = 6'b00_1000,
    ST_FIN   = 6'b01_0000,
    ST_BOOT  = 6'b10_0000
  } emb_state_t;

endpackage : emb_pkg

// ===== verilog/emb_prog_mem.sv
// On-chip program memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module emb_prog_mem (
  input  wire logic                          clk_in,
  input  wire logic                          wr_en_in,
  input  wire logic [emb_pkg::ONCHIP_AW-1:0] wr_addr_in,
  input  wire logic [7:0]                    wr_data_in,
  input  wire logic [emb_pkg::ONCHIP_AW-1:0] rd_addr_in,
  output logic      [7:0]                    rd_data_out
);
  import emb_pkg::*;

  logic [7:0] mem_reg [0:(1<<ONCHIP_AW)-1];

  // No reset on the array, it is loaded over the write port
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  // Read data always comes from a flop
  always_ff @(posedge clk_in) begin
    rd_data_out <= mem_reg[rd_addr_in];
  end

endmodule : emb_prog_mem
`default_nettype wire

// ===== verilog/emb_bus_port.sv
// Multiplexed external memory bus master with on-chip program memory
`timescale 1ns/1ps
`default_nettype none
module emb_bus_port (
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  // Core request and answer
  input  wire logic                          req_valid_in,
  input  wire emb_pkg::emb_req_t             req_in,
  output logic                               req_ready_out,
  output logic                               resp_valid_out,
  output logic      [7:0]                    resp_rdata_out,
  output logic                               start_valid_out,
  output logic      [15:0]                   start_addr_out,
  // Software bus release level
  input  wire logic                          bus_hiz_in,
  // Preload port of on-chip program memory
  input  wire logic                          pmem_wr_en_in,
  input  wire logic [emb_pkg::ONCHIP_AW-1:0] pmem_wr_addr_in,
  input  wire logic [7:0]                    pmem_wr_data_in,
  // External bus pins
  output logic                               address_strobe_n_out,
  output logic                               address_strobe_oe_out,
  output logic                               data_strobe_n_out,
  output logic                               data_strobe_oe_out,
  output logic                               rw_out,
  output logic                               rw_oe_out,
  output logic                               prog_space_out,
  output logic      [7:0]                    ad_out,
  output logic                               ad_oe_out,
  input  wire logic [7:0]                    ad_in,
  output logic      [7:0]                    addr_hi_out,
  output logic                               addr_hi_oe_out
);
  import emb_pkg::*;

  emb_state_t state_reg;
  emb_state_t state_next;
  emb_req_t   cur_reg;
  emb_req_t   cur_next;
  logic [2:0] cnt_reg;
  logic       boot_reg;
  logic       vec_idx_reg;
  logic [7:0] vec_hi_reg;
  logic       hiz_reg;
  logic       cyc_int;
  logic       cyc_ext_wr;
  logic [7:0] ad_s1_reg;
  logic [7:0] ad_s2_reg;
  logic [7:0] ad_s3_reg;
  logic [7:0] ad_filt_reg;
  logic [7:0] pmem_rdata;
  logic       start_cyc;

  assign cyc_int    = cur_reg.prog && (cur_reg.addr < ONCHIP_LIMIT);
  assign cyc_ext_wr = cur_reg.write && !cyc_int;
  assign start_cyc  = (state_reg == ST_IDLE) && (boot_reg || (req_valid_in && !hiz_reg));
  assign req_ready_out = (state_reg == ST_IDLE) && !boot_reg && !hiz_reg;

  emb_prog_mem u_pmem (
    .clk_in      (clk_in),
    .wr_en_in    (pmem_wr_en_in),
    .wr_addr_in  (pmem_wr_addr_in),
    .wr_data_in  (pmem_wr_data_in),
    .rd_addr_in  (cur_reg.addr[ONCHIP_AW-1:0]),
    .rd_data_out (pmem_rdata)
  );

  // Cycle sequencer: strobe, hold, data phase, finish
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_BOOT:  state_next = ST_IDLE;
      ST_IDLE:  if (start_cyc) state_next = ST_AS;
      ST_AS:    if (cnt_reg == AS_LAST) state_next = ST_AHOLD;
      ST_AHOLD: state_next = ST_DS;
      ST_DS:    if (cnt_reg == DS_LAST) state_next = ST_FIN;
      ST_FIN:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= ST_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Phase counter restarts at each strobe phase
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_reg <= CNT_ZERO;
    end else if (state_next != state_reg) begin
      cnt_reg <= CNT_ZERO;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  // vector fetch from 00h then 01h
  always_comb begin
    cur_next = cur_reg;
    if (start_cyc && boot_reg) begin
      cur_next = '{write: 1'b0, prog: 1'b1,
                   addr: vec_idx_reg ? VEC_LO_ADDR : VEC_HI_ADDR, wdata: BYTE_ZERO};
    end else if (start_cyc) begin
      cur_next = req_in;
    end
  end
  // Next request feeds the pins directly, so no stale address shows in the first strobe cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Boot progress and start address handoff
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      boot_reg        <= 1'b1;
      vec_idx_reg     <= 1'b0;
      vec_hi_reg      <= BYTE_ZERO;
      start_valid_out <= 1'b0;
      start_addr_out  <= WORD_ZERO;
    end else begin
      start_valid_out <= 1'b0;
      if (state_reg == ST_FIN && boot_reg) begin
        if (!vec_idx_reg) begin
          vec_hi_reg  <= pmem_rdata;
          vec_idx_reg <= 1'b1;
        end else begin
          boot_reg        <= 1'b0;
          start_valid_out <= 1'b1;
          start_addr_out  <= {vec_hi_reg, pmem_rdata};
        end
      end
    end
  end

  // Three-flop input path; a value counts once stages two and three agree
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ad_s1_reg   <= BYTE_ZERO;
      ad_s2_reg   <= BYTE_ZERO;
      ad_s3_reg   <= BYTE_ZERO;
      ad_filt_reg <= BYTE_ZERO;
    end else begin
      ad_s1_reg <= ad_in;
      ad_s2_reg <= ad_s1_reg;
      ad_s3_reg <= ad_s2_reg;
      if (ad_s2_reg == ad_s3_reg) begin
        ad_filt_reg <= ad_s3_reg;
      end
    end
  end

  // read data taken as the data strobe rises
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      resp_valid_out <= 1'b0;
      resp_rdata_out <= BYTE_ZERO;
    end else begin
      resp_valid_out <= (state_reg == ST_FIN) && !boot_reg;
      if (state_reg == ST_DS && state_next == ST_FIN) begin
        resp_rdata_out <= cyc_int ? pmem_rdata : ad_filt_reg;
      end
    end
  end

  // release only between cycles so no strobe is cut short
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hiz_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && !start_cyc) begin
      hiz_reg <= bus_hiz_in;
    end
  end

  // one address strobe pulse per cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      address_strobe_n_out <= 1'b1;
    end else begin
      address_strobe_n_out <= (state_next != ST_AS);
    end
  end

  // data strobe only for external cycles
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_strobe_n_out <= 1'b1;
    end else begin
      data_strobe_n_out <= !((state_next == ST_DS) && !cyc_int);
    end
  end

  // direction low only through an external write
  // direction and space set one cycle after the address, while the address strobe is low
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rw_out         <= 1'b1;
      prog_space_out <= 1'b1;
    end else begin
      if (state_reg == ST_IDLE) begin
        rw_out <= 1'b1;
      end else if (state_reg == ST_AS) begin
        rw_out <= !cyc_ext_wr;
      end
      if (state_reg == ST_AS) begin
        prog_space_out <= cur_reg.prog;
      end
    end
  end

  // low address then data on port zero, high address on port one
  // write data lands on the same edge as the data strobe falls
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ad_out      <= BYTE_ZERO;
      ad_oe_out   <= 1'b0;
      addr_hi_out <= BYTE_ZERO;
    end else begin
      unique case (state_next)
        ST_AS, ST_AHOLD: begin
          ad_out      <= cur_next.addr[7:0];
          ad_oe_out   <= !hiz_reg;
          addr_hi_out <= cur_next.addr[15:8];
        end
        ST_DS, ST_FIN: begin
          ad_out    <= cur_reg.wdata;
          ad_oe_out <= cyc_ext_wr && !hiz_reg;
        end
        default: begin
          ad_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // all bus drivers except prog_space_out follow the release level
  assign address_strobe_oe_out = !hiz_reg;
  assign data_strobe_oe_out    = !hiz_reg;
  assign rw_oe_out             = !hiz_reg;
  assign addr_hi_oe_out        = !hiz_reg;

  // Checks
  a_as_single_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(address_strobe_n_out) |-> ##1 !address_strobe_n_out ##1 address_strobe_n_out)
    else $error("address strobe pulse not two cycles");

  a_addr_at_rise: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(address_strobe_n_out) |-> $stable(ad_out) && $stable(addr_hi_out) && $stable(rw_out)
      && rw_out == !cyc_ext_wr && prog_space_out == cur_reg.prog)
    else $error("address or direction not valid at strobe rise");

  a_release_all: assert property (@(posedge clk_in) disable iff (!rstn_in)
    hiz_reg |-> !ad_oe_out && !address_strobe_oe_out && !data_strobe_oe_out && !rw_oe_out
      && !addr_hi_oe_out)
    else $error("bus driven while released");

  a_wdata_at_ds: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(data_strobe_n_out) && !rw_out |-> ad_oe_out && ad_out == cur_reg.wdata)
    else $error("write data not valid at data strobe fall");

  a_ds_internal: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_reg != ST_IDLE) && (state_reg != ST_BOOT) && cyc_int |-> data_strobe_n_out)
    else $error("data strobe active on on-chip cycle");

  a_rw_ext_only: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !rw_out || (!data_strobe_n_out && cyc_ext_wr) |-> !rw_out && cyc_ext_wr)
    else $error("direction low outside external write");

  a_boot_fetch: assert property (@(posedge clk_in) disable iff (!rstn_in)
    boot_reg && state_reg == ST_IDLE |=> cur_reg.prog && cur_reg.addr[15:1] == 15'h0000
      ##1 !address_strobe_n_out)
    else $error("vector fetch not from 00h or 01h");

  a_mux_ports: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !address_strobe_n_out |-> ad_out == cur_reg.addr[7:0] && addr_hi_out == cur_reg.addr[15:8])
    else $error("address bytes not on their ports");

  a_ext_above_8k: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(data_strobe_n_out) |-> !(cur_reg.prog && cur_reg.addr < ONCHIP_LIMIT))
    else $error("data strobe for on-chip address");

  c_ext_write: cover property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(data_strobe_n_out) && !rw_out);
  c_ext_read: cover property (@(posedge clk_in) disable iff (!rstn_in)
    $fell(data_strobe_n_out) && rw_out);
  c_boot_done: cover property (@(posedge clk_in) disable iff (!rstn_in) start_valid_out);
  c_released: cover property (@(posedge clk_in) disable iff (!rstn_in) $rose(hiz_reg));

endmodule : emb_bus_port
`default_nettype wire

// ===== verification/emb_mem_model.sv
// External memory with address latch on the far side of the bus port
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
  input  wire logic        clk_in,
  input  wire logic        slow_in,
  input  wire logic        address_strobe_n_in,
  input  wire logic        data_strobe_n_in,
  input  wire logic        rw_in,
  input  wire logic        prog_space_in,
  input  wire logic [7:0]  ad_out_in,
  input  wire logic [7:0]  addr_hi_in,
  output logic      [7:0]  ad_in_out,
  output logic      [15:0] lat_addr_out,
  output logic             lat_prog_out,
  output logic             lat_rw_out
);
  logic [7:0] mem [logic [16:0]];
  logic [7:0] last_val = 8'h00;
  logic       drive    = 1'b0;

  always @(posedge address_strobe_n_in) begin
    lat_addr_out = {addr_hi_in, ad_out_in};
    lat_prog_out = prog_space_in;
    lat_rw_out   = rw_in;
  end

  // Take write data as the strobe rises; data and fall share one edge
  always @(posedge data_strobe_n_in) begin
    if (!lat_rw_out) begin
      mem[{lat_prog_out, lat_addr_out}] = ad_out_in;
    end
  end

  // Read data well before strobe rise; slow answers a cycle late
  always @(negedge data_strobe_n_in) begin
    if (lat_rw_out) begin
      if (slow_in) begin
        @(posedge clk_in);
        #1;
      end
      last_val = mem.exists({lat_prog_out, lat_addr_out}) ?
                 mem[{lat_prog_out, lat_addr_out}] : 8'ha5;
      drive = 1'b1;
    end
  end

  // Released lines show the inverse, not a stale copy
  always @(posedge data_strobe_n_in) drive = 1'b0;
  assign ad_in_out = drive ? last_val : ~last_val;
endmodule : emb_mem_model
`default_nettype wire

// ===== verification/emb_bus_port_tb.sv
// Self-checking bench for the external memory bus port
`timescale 1ns/1ps
`default_nettype none
module emb_bus_port_tb;
  import emb_pkg::*;
  logic        clk_in, rstn_in, req_valid_in, bus_hiz_in, slow;
  logic        pmem_wr_en_in, req_ready_out, resp_valid_out, start_valid_out;
  logic        address_strobe_n_out, address_strobe_oe_out, data_strobe_n_out;
  logic        data_strobe_oe_out, rw_out, rw_oe_out, prog_space_out;
  logic        ad_oe_out, addr_hi_oe_out, lat_prog, lat_rw, w_p;
  logic [12:0] pmem_wr_addr_in;
  logic [7:0]  pmem_wr_data_in, ad_in, ad_out, addr_hi_out, resp_rdata_out, vh, vl, d;
  logic [15:0] start_addr_out, lat_addr, a;
  emb_req_t    req_in;
  int          n_errors, checks, as_cnt, ds_cnt, rw_lo, i;
  logic [7:0]  ref_mem [logic [16:0]];

  emb_bus_port emb_bus_port_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
    .resp_valid_out(resp_valid_out), .resp_rdata_out(resp_rdata_out),
    .start_valid_out(start_valid_out), .start_addr_out(start_addr_out),
    .bus_hiz_in(bus_hiz_in), .pmem_wr_en_in(pmem_wr_en_in),
    .pmem_wr_addr_in(pmem_wr_addr_in), .pmem_wr_data_in(pmem_wr_data_in),
    .address_strobe_n_out(address_strobe_n_out), .address_strobe_oe_out(address_strobe_oe_out),
    .data_strobe_n_out(data_strobe_n_out), .data_strobe_oe_out(data_strobe_oe_out),
    .rw_out(rw_out), .rw_oe_out(rw_oe_out), .prog_space_out(prog_space_out),
    .ad_out(ad_out), .ad_oe_out(ad_oe_out), .ad_in(ad_in),
    .addr_hi_out(addr_hi_out), .addr_hi_oe_out(addr_hi_oe_out));

  emb_mem_model emb_mem_model_inst (.clk_in(clk_in), .slow_in(slow),
    .address_strobe_n_in(address_strobe_n_out), .data_strobe_n_in(data_strobe_n_out),
    .rw_in(rw_out), .prog_space_in(prog_space_out), .ad_out_in(ad_out),
    .addr_hi_in(addr_hi_out), .ad_in_out(ad_in), .lat_addr_out(lat_addr),
    .lat_prog_out(lat_prog), .lat_rw_out(lat_rw));

  // Free-running 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Strobe edge counters, cleared per operation
  always @(negedge address_strobe_n_out) as_cnt++;
  always @(negedge data_strobe_n_out) ds_cnt++;
  always @(negedge rw_out) rw_lo++;

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wrap_up;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task pl(input logic [12:0] pa, input logic [7:0] pd);
    @(posedge clk_in);
    #1;
    pmem_wr_en_in   = 1'b1;
    pmem_wr_addr_in = pa;
    pmem_wr_data_in = pd;
  endtask : pl

  // One request, then compare strobes, latch and data with the bench model
  task do_op(input logic w, input logic p, input logic [15:0] oa, input logic [7:0] od);
    logic ext;
    int   k;
    ext    = !(p && oa < ONCHIP_LIMIT);
    as_cnt = 0;
    ds_cnt = 0;
    rw_lo  = 0;
    @(posedge clk_in);
    #1;
    req_valid_in = 1'b1;
    req_in       = '{write: w, prog: p, addr: oa, wdata: od};
    for (k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (req_ready_out === 1'b1) break;
    end
    #1;
    req_valid_in = 1'b0;
    for (k = 0; k < 20; k++) begin
      if (resp_valid_out === 1'b1) break;
      @(posedge clk_in);
      #1;
    end
    chk(16'(resp_valid_out), 16'h0001);
    chk(16'(as_cnt), 16'h0001);
    chk(16'(ds_cnt), 16'(ext));
    chk(16'(rw_lo), 16'(ext && w));
    chk(lat_addr, oa);
    chk(16'({lat_prog, lat_rw}), 16'({p, !(ext && w)}));
    if (w && ext) ref_mem[{p, oa}] = od;
    if (!w) chk(16'(resp_rdata_out), 16'(ref_mem[{p, oa}]));
  endtask : do_op

  // Hang guard reckoned from some 300 cycles of tests
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {rstn_in, req_valid_in, bus_hiz_in, slow, pmem_wr_en_in} = 5'h00;
    pmem_wr_addr_in = 13'h0000;
    pmem_wr_data_in = 8'h00;
    req_in = '0;
    {n_errors, checks, as_cnt, ds_cnt, rw_lo} = '0;
    void'($urandom(32'h96ac));
    vh = 8'($urandom);
    vl = 8'($urandom);
    pl(13'h0000, vh);
    pl(13'h0001, vl);
    @(posedge clk_in);
    #1;
    pmem_wr_en_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge clk_in);
      #1;
      if (start_valid_out === 1'b1) break;
    end
    chk(start_addr_out, {vh, vl});
    chk(16'(ds_cnt), 16'h0000);
    chk(16'(as_cnt), 16'h0002);
    $display("test boot done");
    d = 8'($urandom);
    ref_mem[{1'b1, 16'h1fff}] = d;
    pl(13'h1fff, d);
    @(posedge clk_in);
    #1;
    pmem_wr_en_in = 1'b0;
    do_op(1'b1, 1'b1, 16'h1fff, ~d);
    do_op(1'b0, 1'b1, 16'h1fff, 8'h00);
    do_op(1'b1, 1'b1, 16'h2000, d);
    do_op(1'b0, 1'b1, 16'h2000, 8'h00);
    $display("test boundary done");
    @(posedge clk_in);
    #1;
    bus_hiz_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk(16'({address_strobe_oe_out, data_strobe_oe_out, rw_oe_out, ad_oe_out,
             addr_hi_oe_out, req_ready_out}), 16'h0000);
    fork
      begin
        repeat (6) @(posedge clk_in);
        #1;
        bus_hiz_in = 1'b0;
      end
      do_op(1'b0, 1'b1, 16'h2000, 8'h00);
    join
    // Drivers back on once released level drops
    chk(16'({address_strobe_oe_out, data_strobe_oe_out, rw_oe_out, addr_hi_oe_out}),
        16'h000f);
    $display("test release done");
    for (i = 0; i < 8; i++) begin
      w_p = 1'($urandom);
      a = 16'($urandom);
      if (w_p) a = 16'h2000 + (a % 16'he000);
      d = 8'($urandom);
      slow = 1'($urandom);
      do_op(1'b1, w_p, a, d);
      do_op(1'b0, w_p, a, 8'h00);
    end
    $display("test random done");
    wrap_up();
  end
endmodule : emb_bus_port_tb
`default_nettype wire
